// [src/pcc_top.sv]
// Purpose: PLL ratio control, clock domain gating and low-power sequencing
// Assumes: sys_clk is the PLL output; the analog PLL, oscillator and flash act on the power outputs
// Notes: All gated clocks come from latch gates fed by registered enables
// Functional notes
// - Ratio select held in bits 11 to 9
// - Ratio codes pick 4x down to 0.5x
// - Ratio resets to all ones, half rate
// - Separate CPU and system clock domains
// - Two-bit select picks light, deep or halt
// - Light sleep stops only the CPU clock
// - Light wake: peripheral, external, protect irq
// - Deep stops CPU and system; wakeup, external or protect irq wakes
// - Halt powers down; reset or protect wakes
// - Six peripheral clock enables, cleared by reset
// - Enables change anytime and gate peripheral clocks
`timescale 1ns/10ps
`include "pcc_regs.svh"
module pcc_top (
  // Clock, reset and freeze
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Register port
  input wire pcc_pkg::pcc_addr_t reg_addr,
  input wire pcc_pkg::pcc_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output pcc_pkg::pcc_word_t reg_rdata,
  // CPU and interrupt requests on sys_clk
  input wire logic idle_req,
  input wire logic periph_irq,
  input wire logic wakeup_irq,
  // Asynchronous pins
  input wire logic ext_irq_pin,
  input wire logic power_drive_protect_irq,
  input wire logic pll_lock_pin,
  // Gated clocks
  output logic cpu_clk,
  output logic system_clock,
  output logic watchdog_timebase_clock,
  output logic pll_output_clock,
  output logic [5:0] periph_clk,
  // Analog control
  output logic pll_ratio_sel_bit2,
  output logic pll_ratio_sel_bit1,
  output logic pll_ratio_sel_bit0,
  output logic pll_power_on,
  output logic osc_power_on,
  output logic flash_power_on
);
  import pcc_pkg::*;

  localparam int NGATE = 10;
  localparam int G_CPU = 0;
  localparam int G_SYS = 1;
  localparam int G_WD = 2;
  localparam int G_PLL = 3;
  localparam int G_PER = 4;

  // Cycle counts derived from the timing figures, least times rounded up
  localparam int SYS_STEP_INT = (`PCC_SYS_STEP_NS + `PCC_CLK_PERIOD_NS - 1) / `PCC_CLK_PERIOD_NS;
  localparam int PLL_SETTLE_INT = (`PCC_PLL_SETTLE_NS + `PCC_CLK_PERIOD_NS - 1) / `PCC_CLK_PERIOD_NS;
  localparam logic [7:0] SYS_STEP_CYC = 8'(SYS_STEP_INT < 1 ? 1 : SYS_STEP_INT);
  localparam logic [7:0] PLL_SETTLE_CYC = 8'(PLL_SETTLE_INT < 1 ? 1 : PLL_SETTLE_INT);

  pcc_state_t st;
  pcc_state_t next_st;
  logic [NGATE-1:0] gate_en;
  logic [NGATE-1:0] gate_clk;
  logic ext_irq;
  logic pdp_irq;
  logic pll_locked;
  logic wr_ctl;
  logic rd_ctl;
  logic rd_stat;

  // Address match shared by the read and write paths
  function automatic logic addr_hit(input pcc_addr_t a, input pcc_addr_t target);
    addr_hit = (a == target);
  endfunction

  // Wake decision for the current sleep state
  function automatic logic wake_hit(input pcc_pwr_state_t s, input logic per, input logic wku,
                                    input logic ext, input logic pdp);
    case (s)
      PCC_LIGHT: wake_hit = per | ext | pdp;
      PCC_DEEP: wake_hit = wku | ext | pdp;
      PCC_HALT: wake_hit = pdp;
      default: wake_hit = 1'b0;
    endcase
  endfunction

  // Synchronised pin levels, read only from the second stage
  assign ext_irq = st.ext_sync[1];
  assign pdp_irq = st.pdp_sync[1];
  assign pll_locked = st.lock_sync[1];

  // Register strobes
  assign wr_ctl = reg_wr & addr_hit(reg_addr, `PCC_SCS1_ADDR);
  assign rd_ctl = reg_rd & addr_hit(reg_addr, `PCC_SCS1_ADDR);
  assign rd_stat = reg_rd & addr_hit(reg_addr, `PCC_STAT_ADDR);

  // Next state of the whole block
  always_comb begin
    next_st = st;
    next_st.ext_sync = {st.ext_sync[0], ext_irq_pin};
    next_st.pdp_sync = {st.pdp_sync[0], power_drive_protect_irq};
    next_st.lock_sync = {st.lock_sync[0], pll_lock_pin};
    next_st.rdata = 16'h0000;

    // Control register write, allowed in any state
    if (wr_ctl) begin
      next_st.ratio = reg_wdata[`PCC_RATIO_MSB:`PCC_RATIO_LSB];
      next_st.sleep_sel = reg_wdata[`PCC_SLEEP_MSB:`PCC_SLEEP_LSB];
      next_st.pen = reg_wdata[`PCC_PEN_MSB:`PCC_PEN_LSB];
    end

    // Read data, valid only in the cycle after the strobe
    if (rd_ctl) begin
      next_st.rdata[`PCC_RATIO_MSB:`PCC_RATIO_LSB] = st.ratio;
      next_st.rdata[`PCC_SLEEP_MSB:`PCC_SLEEP_LSB] = st.sleep_sel;
      next_st.rdata[`PCC_PEN_MSB:`PCC_PEN_LSB] = st.pen;
    end else if (rd_stat) begin
      next_st.rdata[`PCC_ST_CPU] = st.cpu_on;
      next_st.rdata[`PCC_ST_SYS] = st.sys_on;
      next_st.rdata[`PCC_ST_WD] = st.wd_on;
      next_st.rdata[`PCC_ST_PLL] = st.pll_on;
      next_st.rdata[`PCC_ST_LOCK] = pll_locked;
      next_st.rdata[`PCC_ST_FSM_MSB:`PCC_ST_FSM_LSB] = st.fsm;
    end

    // Step counter runs down to zero
    if (st.cnt != 8'h00) begin
      next_st.cnt = st.cnt - 8'h01;
    end

    // Power sequencer
    case (st.fsm)
      PCC_RUN: begin
        if (idle_req) begin
          next_st.mode = st.sleep_sel;
          next_st.cpu_on = 1'b0;
          next_st.fsm = PCC_LIGHT;
        end
      end
      PCC_LIGHT: begin
        if (wake_hit(PCC_LIGHT, periph_irq, wakeup_irq, ext_irq, pdp_irq)) begin
          next_st.cpu_on = 1'b1;
          next_st.fsm = PCC_RUN;
        end else if (st.mode != 2'h0) begin
          next_st.sys_on = 1'b0;
          next_st.fsm = PCC_DEEP;
        end
      end
      PCC_DEEP: begin
        if (wake_hit(PCC_DEEP, periph_irq, wakeup_irq, ext_irq, pdp_irq)) begin
          next_st.cnt = SYS_STEP_CYC;
          next_st.fsm = PCC_WAKE_SYS;
        end else if (st.mode[1]) begin
          next_st.wd_on = 1'b0;
          next_st.pll_on = 1'b0;
          next_st.fsm = PCC_HALT;
        end
      end
      PCC_HALT: begin
        if (wake_hit(PCC_HALT, periph_irq, wakeup_irq, ext_irq, pdp_irq)) begin
          next_st.pll_on = 1'b1;
          next_st.cnt = PLL_SETTLE_CYC;
          next_st.fsm = PCC_WAKE_PLL;
        end
      end
      PCC_WAKE_PLL: begin
        // CPU, system and watchdog clocks stay off until the loop has locked and settled
        if (!pll_locked) begin
          next_st.cnt = PLL_SETTLE_CYC;
        end else if (st.cnt == 8'h00) begin
          next_st.wd_on = 1'b1;
          next_st.cnt = SYS_STEP_CYC;
          next_st.fsm = PCC_WAKE_SYS;
        end
      end
      PCC_WAKE_SYS: begin
        next_st.sys_on = 1'b1;
        if (st.cnt == 8'h00) begin
          next_st.cpu_on = 1'b1;
          next_st.fsm = PCC_RUN;
        end
      end
      default: begin
        next_st.fsm = PCC_RUN;
        next_st.cpu_on = 1'b1;
        next_st.sys_on = 1'b1;
        next_st.wd_on = 1'b1;
        next_st.pll_on = 1'b1;
      end
    endcase
  end

  // State register with freeze
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st.fsm <= PCC_RUN;
      st.ratio <= `PCC_RATIO_RST;
      st.sleep_sel <= `PCC_SLEEP_RST;
      st.pen <= `PCC_PEN_RST;
      st.mode <= 2'h0;
      st.cnt <= 8'h00;
      st.cpu_on <= 1'b1;
      st.sys_on <= 1'b1;
      st.wd_on <= 1'b1;
      st.pll_on <= 1'b1;
      st.lock_sync <= 2'h0;
      st.ext_sync <= 2'h0;
      st.pdp_sync <= 2'h0;
      st.rdata <= 16'h0000;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // Gate enables; the system domain also feeds the peripherals
  always_comb begin
    gate_en = '0;
    gate_en[G_CPU] = st.cpu_on;
    gate_en[G_SYS] = st.sys_on;
    gate_en[G_WD] = st.wd_on;
    gate_en[G_PLL] = st.pll_on;
    gate_en[G_PER +: 6] = st.pen & {6{st.sys_on}};
  end

  // One glitch-free gate per clock
  generate
    for (genvar i = 0; i < NGATE; i++) begin : g_gate
      pcc_gate_if gif (.clk(sys_clk));
      assign gif.enable = gate_en[i];
      assign gate_clk[i] = gif.gclk;
      pcc_clk_gate u_gate (
        .g(gif)
      );
    end
  endgenerate

  // Clock outputs
  assign cpu_clk = gate_clk[G_CPU];
  assign system_clock = gate_clk[G_SYS];
  assign watchdog_timebase_clock = gate_clk[G_WD];
  assign pll_output_clock = gate_clk[G_PLL];
  assign periph_clk = gate_clk[G_PER +: 6];

  // Ratio code to the PLL multiplier
  assign pll_ratio_sel_bit2 = st.ratio[2];
  assign pll_ratio_sel_bit1 = st.ratio[1];
  assign pll_ratio_sel_bit0 = st.ratio[0];

  // Analog power controls follow the PLL state
  assign pll_power_on = st.pll_on;
  assign osc_power_on = st.pll_on;
  assign flash_power_on = st.pll_on;

  // Read data register
  assign reg_rdata = st.rdata;
endmodule

// [src/pcc_regs.svh]
// Purpose: Offsets, field positions, reset values and timing figures of the clock and power controller
// Assumes: 16-bit register data, 8-bit register address
// Notes: Included by its bare name from the top module
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH

// Register offsets
`define PCC_SCS1_ADDR 8'h00
`define PCC_STAT_ADDR 8'h01

// Control register fields
`define PCC_RATIO_MSB 11
`define PCC_RATIO_LSB 9
`define PCC_SLEEP_MSB 13
`define PCC_SLEEP_LSB 12
`define PCC_PEN_MSB 7
`define PCC_PEN_LSB 2

// Peripheral enable positions inside the enable field
`define PCC_PEN_EVA 0
`define PCC_PEN_EVB 1
`define PCC_PEN_CAN 2
`define PCC_PEN_SPI 3
`define PCC_PEN_SCI 4
`define PCC_PEN_ADC 5

// Status register fields
`define PCC_ST_CPU 0
`define PCC_ST_SYS 1
`define PCC_ST_WD 2
`define PCC_ST_PLL 3
`define PCC_ST_LOCK 4
`define PCC_ST_FSM_MSB 7
`define PCC_ST_FSM_LSB 5

// Reset values
`define PCC_RATIO_RST 3'h7
`define PCC_SLEEP_RST 2'h0
`define PCC_PEN_RST 6'h00

// Timing figures in ns
`define PCC_CLK_PERIOD_NS 10
`define PCC_SYS_STEP_NS 20
`define PCC_PLL_SETTLE_NS 1000

`endif

// [src/pcc_pkg.sv]
// Purpose: Types shared by the clock and power controller files
// Assumes: Constants come from pcc_regs.svh
// Notes: Power states are Gray coded along the sleep path and the wake path from halt
package pcc_pkg;

  typedef logic [7:0] pcc_addr_t;
  typedef logic [15:0] pcc_word_t;

  // Power sequencer states
  typedef enum logic [2:0] {
    PCC_RUN = 3'h0,
    PCC_LIGHT = 3'h1,
    PCC_DEEP = 3'h3,
    PCC_HALT = 3'h2,
    PCC_WAKE_PLL = 3'h6,
    PCC_WAKE_SYS = 3'h4
  } pcc_pwr_state_t;

  // Complete register state of the top module
  typedef struct packed {
    pcc_pwr_state_t fsm;
    logic [2:0] ratio;
    logic [1:0] sleep_sel;
    logic [5:0] pen;
    logic [1:0] mode;
    logic [7:0] cnt;
    logic cpu_on;
    logic sys_on;
    logic wd_on;
    logic pll_on;
    logic [1:0] lock_sync;
    logic [1:0] ext_sync;
    logic [1:0] pdp_sync;
    logic [15:0] rdata;
  } pcc_state_t;

endpackage

// [src/pcc_gate_if.sv]
// Purpose: Carrier between the controller and one clock gate
// Assumes: Enable changes only on the rising edge of clk
// Notes: The gated clock returns to the controller
`timescale 1ns/10ps
interface pcc_gate_if (
  input wire logic clk
);
  logic enable;
  logic gclk;

  modport ctrl (input clk, output enable, input gclk);
  modport gate (input clk, input enable, output gclk);
endinterface

// [src/pcc_clk_gate.sv]
// Purpose: Glitch-free clock gate
// Assumes: Enable is launched from the rising edge of the source clock
// Notes: Latch is open while the clock is low, so the enable cannot cut a high phase
`timescale 1ns/10ps
module pcc_clk_gate (
  // Gate carrier
  pcc_gate_if.gate g
);
  logic en_lat;

  // Hold enable through the high phase
  always_latch begin
    if (!g.clk) begin
      en_lat <= g.enable;
    end
  end

  // Gated output
  assign g.gclk = g.clk & en_lat;
endmodule

// [dv/pcc_monitor.sv]
// Purpose: Port checker for the clock and power controller
// Assumes: A gated clock sampled at the falling edge shows its gate enable
// Notes: Bound into every pcc_top
`timescale 1ns/10ps
module pcc_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Register port
  input wire pcc_pkg::pcc_addr_t reg_addr,
  input wire pcc_pkg::pcc_word_t reg_wdata,
  input wire logic reg_wr,
  // Requests
  input wire logic idle_req,
  input wire logic periph_irq,
  input wire logic power_drive_protect_irq,
  // Clocks and power
  input wire logic cpu_clk,
  input wire logic system_clock,
  input wire logic watchdog_timebase_clock,
  input wire logic [5:0] periph_clk,
  input wire logic pll_ratio_sel_bit2,
  input wire logic pll_ratio_sel_bit1,
  input wire logic pll_ratio_sel_bit0,
  input wire logic pll_power_on
);
  import pcc_pkg::*;
  logic [2:0] ratio;
  // Ratio pins as one code
  assign ratio = {pll_ratio_sel_bit2, pll_ratio_sel_bit1, pll_ratio_sel_bit0};
  // Falling edge sees the enables behind the gates
  default clocking cb @(negedge sys_clk);
  endclocking
  default disable iff (!resetn);
  property p_ratio_wr;
    reg_wr && reg_addr == 8'h00 && clk_en |=> ratio == $past(reg_wdata[11:9]);
  endproperty
  a_ratio_wr: assert property (p_ratio_wr) else $error("ratio pins differ from written code");
  property p_rst;
    $rose(resetn) |-> ratio == 3'h7 && periph_clk == 6'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_nest;
    cpu_clk |-> system_clock && watchdog_timebase_clock;
  endproperty
  a_nest: assert property (p_nest) else $error("cpu clock runs without system clock");
  property p_idle;
    idle_req && cpu_clk && clk_en |-> ##2 !cpu_clk;
  endproperty
  a_idle: assert property (p_idle) else $error("cpu clock kept after idle");
  property p_light_wake;
    !cpu_clk && system_clock && periph_irq && clk_en |-> ##[1:4] cpu_clk;
  endproperty
  a_light_wake: assert property (p_light_wake) else $error("no wake from light sleep");
  property p_halt_stay;
    (!power_drive_protect_irq && !pll_power_on) [*4] |=> !pll_power_on;
  endproperty
  a_halt_stay: assert property (p_halt_stay) else $error("halt left without protect irq");
  property p_wake_order;
    $rose(cpu_clk) |-> $past(system_clock, 2) && watchdog_timebase_clock;
  endproperty
  a_wake_order: assert property (p_wake_order) else $error("cpu clock restarted too early");
  property p_pen;
    reg_wr && reg_addr == 8'h00 && clk_en && system_clock ##2 system_clock |-> periph_clk == $past(reg_wdata[7:2], 2);
  endproperty
  a_pen: assert property (p_pen) else $error("peripheral clocks differ from enables");
endmodule

bind pcc_top pcc_monitor pcc_monitor_inst (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .idle_req(idle_req), .periph_irq(periph_irq),
  .power_drive_protect_irq(power_drive_protect_irq), .cpu_clk(cpu_clk), .system_clock(system_clock),
  .watchdog_timebase_clock(watchdog_timebase_clock), .periph_clk(periph_clk),
  .pll_ratio_sel_bit2(pll_ratio_sel_bit2), .pll_ratio_sel_bit1(pll_ratio_sel_bit1),
  .pll_ratio_sel_bit0(pll_ratio_sel_bit0), .pll_power_on(pll_power_on));

// [dv/pcc_pll_model.sv]
// Purpose: Behavioural lock detector of the analog PLL
// Assumes: Lock drops at once when power goes
// Notes: Lock delay is a plain default
`timescale 1ns/10ps
module pcc_pll_model #(parameter int LOCK_CYCLES = 20) (
  // Reference and power
  input wire logic ref_clk,
  input wire logic power_on,
  // Lock indication
  output logic lock
);
  int cnt = 0;
  // Counts reference cycles while powered
  always @(posedge ref_clk or negedge power_on) begin
    if (!power_on) begin
      cnt <= 0;
    end else if (cnt < LOCK_CYCLES) begin
      cnt <= cnt + 1;
    end
  end
  assign lock = power_on && cnt == LOCK_CYCLES;
endmodule

// [dv/tb_top.sv]
// Purpose: Self-checking bench for the clock and power controller
// Assumes: Control at 0x00, status at 0x01
// Notes: Irq vector bits are periph, wakeup, external, protect
`timescale 1ns/10ps
module tb_top;
  import pcc_pkg::*;
  logic sys_clk = 0;
  logic resetn = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic idle_req = 0;
  logic clk_en = 1;
  logic osc_on, flash_on;
  logic [3:0] irq = 4'h0;
  pcc_addr_t reg_addr = 8'h00;
  pcc_word_t reg_wdata = 16'h0000;
  pcc_word_t reg_rdata;
  pcc_word_t rd;
  logic cpu_clk, system_clock, wd_clk, pll_clk, b2, b1, b0, pll_power_on, lock;
  logic [5:0] periph_clk;
  int fails = 0;
  int n_compared = 0;
  always #5 sys_clk = ~sys_clk;
  pcc_top pcc_top_inst (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_req(idle_req),
    .periph_irq(irq[0]), .wakeup_irq(irq[1]), .ext_irq_pin(irq[2]), .power_drive_protect_irq(irq[3]),
    .pll_lock_pin(lock), .cpu_clk(cpu_clk), .system_clock(system_clock), .watchdog_timebase_clock(wd_clk),
    .pll_output_clock(pll_clk), .periph_clk(periph_clk), .pll_ratio_sel_bit2(b2), .pll_ratio_sel_bit1(b1),
    .pll_ratio_sel_bit0(b0), .pll_power_on(pll_power_on), .osc_power_on(osc_on), .flash_power_on(flash_on));
  pcc_pll_model pcc_pll_model_inst (.ref_clk(sys_clk), .power_on(pll_power_on), .lock(lock));
  task end_of_test;
    $display("compared %0d wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task cmp_word(input pcc_word_t got, input pcc_word_t exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus master cycles
  task wr(input pcc_addr_t a, input pcc_word_t d);
    @(posedge sys_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask
  task rdr(input pcc_addr_t a);
    @(posedge sys_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 0;
    #1 rd = reg_rdata;
  endtask
  // Clocks sampled inside the high phase; oscillator and flash power follow the PLL clock
  task chk_clk(input logic [9:0] e);
    @(posedge sys_clk);
    #2 cmp_word({4'h0, osc_on, flash_on, cpu_clk, system_clock, wd_clk, pll_clk, periph_clk}, {4'h0, e[6], e[6], e});
  endtask
  task status(input logic [2:0] st, input logic [3:0] on);
    rdr(8'h01);
    cmp_word(rd & 16'h00EF, {8'h00, st, 1'b0, on});
  endtask
  task pulse(input logic [3:0] m);
    @(posedge sys_clk);
    irq <= m;
    repeat (3) @(posedge sys_clk);
    irq <= 4'h0;
    repeat (6) @(posedge sys_clk);
  endtask
  task wait_run;
    for (int i = 0; i < 200; i++) begin
      rdr(8'h01);
      if (rd[7:5] === 3'h0 && rd[0] === 1'b1) return;
    end
    fails++;
    end_of_test;
  endtask
  // Enter a sleep mode, try a wrong source, then a right one unless good is zero
  task sleep(input logic [1:0] sel, input logic [2:0] st, input logic [3:0] on, input logic [3:0] bad,
             input logic [3:0] good);
    wr(8'h00, {2'b00, sel, 12'hE00});
    @(posedge sys_clk);
    idle_req <= 1;
    @(posedge sys_clk);
    idle_req <= 0;
    repeat (3) @(posedge sys_clk);
    status(st, on);
    chk_clk({on[0], on[1], on[2], on[3], 6'h00});
    pulse(bad);
    status(st, on);
    if (good != 4'h0) begin
      pulse(good);
      wait_run;
      status(PCC_RUN, 4'hF);
    end
  endtask
  task t_reset;
    status(PCC_RUN, 4'hF);
    rdr(8'h00);
    cmp_word(rd, 16'h0E00);
    chk_clk(10'h3C0);
    wr(8'h01, 16'hFFFF);
    rdr(8'h05);
    cmp_word(rd, 16'h0000);
    status(PCC_RUN, 4'hF);
  endtask
  task t_ratio;
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, 16'(i) << 9);
      rdr(8'h00);
      cmp_word(rd, 16'(i) << 9);
      cmp_word({13'h0000, b2, b1, b0}, 16'(i));
    end
  endtask
  task t_pen;
    for (int i = 0; i < 6; i++) begin
      wr(8'h00, 16'h0E00 | (16'h0004 << i));
      chk_clk({4'hF, 6'h01 << i});
    end
    wr(8'h00, 16'h0E00);
    chk_clk(10'h3C0);
  endtask
  // Strobes are ignored while the block is frozen
  task t_freeze;
    @(posedge sys_clk);
    clk_en <= 0;
    wr(8'h00, 16'h0200);
    @(posedge sys_clk);
    clk_en <= 1;
    rdr(8'h00);
    cmp_word(rd, 16'h0E00);
  endtask
  task t_light;
    sleep(2'b00, PCC_LIGHT, 4'hE, 4'b0010, 4'b0001);
    sleep(2'b00, PCC_LIGHT, 4'hE, 4'b0010, 4'b0100);
    sleep(2'b00, PCC_LIGHT, 4'hE, 4'b0010, 4'b1000);
  endtask
  task t_deep;
    sleep(2'b01, PCC_DEEP, 4'hC, 4'b0001, 4'b0010);
    sleep(2'b01, PCC_DEEP, 4'hC, 4'b0001, 4'b0100);
  endtask
  task t_halt;
    sleep(2'b10, PCC_HALT, 4'h0, 4'b0111, 4'b1000);
    sleep(2'b11, PCC_HALT, 4'h0, 4'b0111, 4'b0000);
    @(posedge sys_clk);
    resetn <= 0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1;
    status(PCC_RUN, 4'hF);
    rdr(8'h00);
    cmp_word(rd, 16'h0E00);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1;
    t_reset;
    t_ratio;
    t_pen;
    t_freeze;
    t_light;
    t_deep;
    t_halt;
    end_of_test;
  end
endmodule
